/* File: hdl/mcct_pkg.sv */
// Shared constants and types for the match/capture counter/timer block
package mcct_pkg;

    // ========================================================================
    // Structure
    localparam int NUM_TIMERS = 4;
    localparam int NUM_LONG   = 2;
    localparam int NUM_CH     = 4;

    // ========================================================================
    // Register offsets inside one timer window (byte addresses, low 6 bits)
    localparam logic [5:0] OFS_CTRL      = 6'h00;
    localparam logic [5:0] OFS_COUNT     = 6'h04;
    localparam logic [5:0] OFS_PRE_VAL   = 6'h08;
    localparam logic [5:0] OFS_PRE_CNT   = 6'h0C;
    localparam logic [5:0] OFS_MATCH_CTL = 6'h10;
    localparam logic [5:0] OFS_MATCH0    = 6'h14;
    localparam logic [5:0] OFS_CAP_CTL   = 6'h24;
    localparam logic [5:0] OFS_CAP0      = 6'h28;
    localparam logic [5:0] OFS_FLAGS     = 6'h38;
    localparam logic [5:0] OFS_EXT_CTL   = 6'h3C;
    localparam logic [5:0] OFS_STEP      = 6'h04;

    // Address split: [7:6] selects the timer, [31:8] must be zero
    localparam int ADDR_TMR_LO = 6;
    localparam int ADDR_HI_LO  = 8;

    // ========================================================================
    // Field positions
    localparam int CTRL_EN         = 0;
    localparam int CTRL_RST        = 1;
    localparam int CTRL_CNT_MODE   = 2;
    localparam int CTRL_CNT_SEL_LO = 4;
    localparam int CTRL_CMP_SRC    = 6;
    localparam int CTRL_DMA_LO     = 8;
    localparam logic [31:0] CTRL_MASK = 32'h00000F77;

    localparam int MCTL_INT   = 0;
    localparam int MCTL_RESET = 1;
    localparam int MCTL_STOP  = 2;
    localparam int MCTL_STEP  = 3;
    localparam logic [31:0] MCTL_MASK = 32'h00000FFF;

    localparam int CCTL_RISE      = 0;
    localparam int CCTL_FALL      = 1;
    localparam int CCTL_INT       = 2;
    localparam int CCTL_STEP      = 3;
    localparam int CCTL_CLR_EN    = 12;
    localparam int CCTL_CLR_SEL_LO = 13;
    localparam logic [31:0] CCTL_MASK = 32'h00007FFF;

    localparam int FLAG_CAP_LO = 4;
    localparam int EXT_ACT_LO  = 4;
    localparam logic [31:0] EXT_MASK = 32'h00000FFF;

    localparam logic [31:0] RST_WORD = 32'h00000000;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        EXT_KEEP   = 2'b00,
        EXT_LOW    = 2'b01,
        EXT_HIGH   = 2'b10,
        EXT_TOGGLE = 2'b11
    } mcct_ext_action_type;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/mcct_sync_edge.sv */
// Three-stage input synchroniser with filtered level and edge pulses
`timescale 1ns/100ps
`default_nettype none

module mcct_sync_edge (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
    logic settled;

    // ========================================================================
    // Synchroniser; stage1 feeds stage2 only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once stages two and three agree
    assign settled = (stage2 == stage3);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (settled) begin
            level <= stage3;
        end
    end

    assign rise = settled && stage3 && !level;
    assign fall = settled && !stage3 && level;

endmodule
`default_nettype wire

/* File: hdl/mcct_top.sv */
// Four counter/timers (two long, two short) behind an AXI4-Lite slave
//
// Function
// - Two long and two short timer instances
// - Prescaler as wide as its counter
// - Timer mode counts prescaled system clock
// - Counter mode counts rising edges of the selected input
// - Four writable match values per timer
// - Match may keep counting, optional interrupt
// - Match may halt counter, optional interrupt
// - Match may zero counter, optional interrupt
// - One external output per match value
// - Output goes low, high, toggles or holds
// - Capture copies counter on input edge
// - Per-channel capture interrupt enable
// - Chosen capture may clear counter and prescaler
// - Match events pace DMA request pulses
// - Two timers accept comparator outputs as captures
`timescale 1ns/100ps
`default_nettype none

module mcct_top #(
    parameter int LONG_WIDTH  = 32,
    parameter int SHORT_WIDTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  long_timer_a_capture_in,
    input  wire logic [3:0]  long_timer_b_capture_in,
    input  wire logic [3:0]  short_timer_a_capture_in,
    input  wire logic [3:0]  short_timer_b_capture_in,
    input  wire logic [1:0]  comparator_out,
    output logic [3:0]       long_timer_a_match_out,
    output logic [3:0]       long_timer_b_match_out,
    output logic [3:0]       short_timer_a_match_out,
    output logic [3:0]       short_timer_b_match_out,
    output logic [3:0]       timer_irq,
    output logic [3:0]       timer_dma_req
);

    // ========================================================================
    // Storage shared by all timers
    logic [31:0] ctrl      [mcct_pkg::NUM_TIMERS];
    logic [31:0] count     [mcct_pkg::NUM_TIMERS];
    logic [31:0] pre_val   [mcct_pkg::NUM_TIMERS];
    logic [31:0] pre_cnt   [mcct_pkg::NUM_TIMERS];
    logic [31:0] match_ctl [mcct_pkg::NUM_TIMERS];
    logic [31:0] cap_ctl   [mcct_pkg::NUM_TIMERS];
    logic [31:0] ext_ctl   [mcct_pkg::NUM_TIMERS];
    logic [31:0] match_val [mcct_pkg::NUM_TIMERS][mcct_pkg::NUM_CH];
    logic [31:0] cap_val   [mcct_pkg::NUM_TIMERS][mcct_pkg::NUM_CH];
    logic [7:0]  flags     [mcct_pkg::NUM_TIMERS];
    logic [3:0]  cap_pin   [mcct_pkg::NUM_TIMERS];
    logic [3:0]  irq_q;
    logic [3:0]  dma_q;

    assign cap_pin[0] = long_timer_a_capture_in;
    assign cap_pin[1] = long_timer_b_capture_in;
    assign cap_pin[2] = short_timer_a_capture_in;
    assign cap_pin[3] = short_timer_b_capture_in;

    assign long_timer_a_match_out  = ext_ctl[0][3:0];
    assign long_timer_b_match_out  = ext_ctl[1][3:0];
    assign short_timer_a_match_out = ext_ctl[2][3:0];
    assign short_timer_b_match_out = ext_ctl[3][3:0];
    assign timer_irq               = irq_q;
    assign timer_dma_req           = dma_q;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ========================================================================
    // AXI4-Lite write channel
    logic       wr_fire;
    logic       wr_ok;
    logic [1:0] wr_tmr;
    logic [5:0] wr_reg;

    // Address and data are taken together, so a write is one atomic event
    assign wr_fire = s_axi_awready;
    assign wr_ok   = (s_axi_awaddr[31:mcct_pkg::ADDR_HI_LO] == 24'h000000);
    assign wr_tmr  = s_axi_awaddr[mcct_pkg::ADDR_HI_LO-1:mcct_pkg::ADDR_TMR_LO];
    assign wr_reg  = {s_axi_awaddr[5:2], 2'h0};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mcct_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? mcct_pkg::RESP_OKAY : mcct_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================================
    // AXI4-Lite read channel
    logic [31:0] rd_word;
    logic        rd_ok;
    logic [1:0]  rd_tmr;
    logic [5:0]  rd_reg;

    assign rd_ok  = (s_axi_araddr[31:mcct_pkg::ADDR_HI_LO] == 24'h000000);
    assign rd_tmr = s_axi_araddr[mcct_pkg::ADDR_HI_LO-1:mcct_pkg::ADDR_TMR_LO];
    assign rd_reg = {s_axi_araddr[5:2], 2'h0};

    always_comb begin
        if (!rd_ok) begin
            rd_word = mcct_pkg::RST_WORD;
        end else if (rd_reg == mcct_pkg::OFS_CTRL) begin
            rd_word = ctrl[rd_tmr];
        end else if (rd_reg == mcct_pkg::OFS_COUNT) begin
            rd_word = count[rd_tmr];
        end else if (rd_reg == mcct_pkg::OFS_PRE_VAL) begin
            rd_word = pre_val[rd_tmr];
        end else if (rd_reg == mcct_pkg::OFS_PRE_CNT) begin
            rd_word = pre_cnt[rd_tmr];
        end else if (rd_reg == mcct_pkg::OFS_MATCH_CTL) begin
            rd_word = match_ctl[rd_tmr];
        end else if (rd_reg < mcct_pkg::OFS_CAP_CTL) begin
            rd_word = match_val[rd_tmr][rd_reg[3:2] - 2'h1];
        end else if (rd_reg == mcct_pkg::OFS_CAP_CTL) begin
            rd_word = cap_ctl[rd_tmr];
        end else if (rd_reg < mcct_pkg::OFS_FLAGS) begin
            rd_word = cap_val[rd_tmr][rd_reg[3:2] - 2'h2];
        end else if (rd_reg == mcct_pkg::OFS_FLAGS) begin
            rd_word = {24'h000000, flags[rd_tmr]};
        end else begin
            rd_word = ext_ctl[rd_tmr];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= mcct_pkg::RST_WORD;
            s_axi_rresp  <= mcct_pkg::RESP_OKAY;
        end else if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? mcct_pkg::RESP_OKAY : mcct_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================================
    // Timer instances
    // four instances, widths
    for (genvar i = 0; i < mcct_pkg::NUM_TIMERS; i++) begin : g_tmr
        localparam int          WIDTH = (i < mcct_pkg::NUM_LONG) ? LONG_WIDTH : SHORT_WIDTH;
        localparam logic [31:0] MASK  = 32'hFFFFFFFF >> (32 - WIDTH);

        logic [3:0]  src;
        logic [3:0]  rise;
        logic [3:0]  fall;
        logic [3:0]  m_hit;
        logic [3:0]  c_hit;
        logic        sel;
        logic        tick;
        logic        pre_wrap;
        logic        m_reset;
        logic        m_stop;
        logic        clr_cap;
        logic [31:0] inc;
        logic [31:0] wr_word;
        logic [7:0]  int_en;

        assign sel     = wr_fire && wr_ok && (wr_tmr == 2'(i));
        assign wr_word = s_axi_wdata;

        for (genvar j = 0; j < mcct_pkg::NUM_CH; j++) begin : g_ch
            if (i < mcct_pkg::NUM_LONG && j == mcct_pkg::NUM_CH - 1) begin : g_cmp
                assign src[j] = ctrl[i][mcct_pkg::CTRL_CMP_SRC] ? comparator_out[i]
                                                                : cap_pin[i][j];
            end else begin : g_pin
                assign src[j] = cap_pin[i][j];
            end

            mcct_sync_edge u_sync (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .pin_in  (src[j]),
                .rise    (rise[j]),
                .fall    (fall[j])
            );
        end

        always_comb begin
            tick = ctrl[i][mcct_pkg::CTRL_EN] && !ctrl[i][mcct_pkg::CTRL_RST];
            // counter mode ticks on rising edges of the selected input
            if (ctrl[i][mcct_pkg::CTRL_CNT_MODE]) begin
                tick = tick && rise[ctrl[i][mcct_pkg::CTRL_CNT_SEL_LO +: 2]];
            end
            pre_wrap = tick && (pre_cnt[i] == pre_val[i]);
            inc      = (count[i] + 32'h00000001) & MASK;
            m_reset  = 1'b0;
            m_stop   = 1'b0;
            for (int j = 0; j < mcct_pkg::NUM_CH; j++) begin
                m_hit[j] = pre_wrap && (inc == match_val[i][j]);
                m_reset  = m_reset || (m_hit[j] && match_ctl[i][j*mcct_pkg::MCTL_STEP + mcct_pkg::MCTL_RESET]);
                m_stop   = m_stop || (m_hit[j] && match_ctl[i][j*mcct_pkg::MCTL_STEP + mcct_pkg::MCTL_STOP]);
                c_hit[j] = (rise[j] && cap_ctl[i][j*mcct_pkg::CCTL_STEP + mcct_pkg::CCTL_RISE]) ||
                           (fall[j] && cap_ctl[i][j*mcct_pkg::CCTL_STEP + mcct_pkg::CCTL_FALL]);
                int_en[j] = match_ctl[i][j*mcct_pkg::MCTL_STEP + mcct_pkg::MCTL_INT];
                int_en[mcct_pkg::FLAG_CAP_LO + j] = cap_ctl[i][j*mcct_pkg::CCTL_STEP + mcct_pkg::CCTL_INT];
            end
            clr_cap = cap_ctl[i][mcct_pkg::CCTL_CLR_EN] &&
                      c_hit[cap_ctl[i][mcct_pkg::CCTL_CLR_SEL_LO +: 2]];
        end

        // keep running or zero on match
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                count[i] <= mcct_pkg::RST_WORD;
            end else if (ctrl[i][mcct_pkg::CTRL_RST] || clr_cap) begin
                count[i] <= mcct_pkg::RST_WORD;
            end else if (pre_wrap) begin
                count[i] <= m_reset ? mcct_pkg::RST_WORD : inc;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                pre_cnt[i] <= mcct_pkg::RST_WORD;
            end else if (ctrl[i][mcct_pkg::CTRL_RST] || clr_cap) begin
                pre_cnt[i] <= mcct_pkg::RST_WORD;
            end else if (tick) begin
                pre_cnt[i] <= pre_wrap ? mcct_pkg::RST_WORD : ((pre_cnt[i] + 32'h00000001) & MASK);
            end
        end

        // Halt on match beats a same-cycle software enable
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ctrl[i] <= mcct_pkg::RST_WORD;
            end else begin
                if (sel && wr_reg == mcct_pkg::OFS_CTRL) begin
                    ctrl[i] <= merge_bytes(ctrl[i], wr_word, s_axi_wstrb) & mcct_pkg::CTRL_MASK;
                end
                if (m_stop) begin
                    ctrl[i][mcct_pkg::CTRL_EN] <= 1'b0;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                pre_val[i]   <= mcct_pkg::RST_WORD;
                match_ctl[i] <= mcct_pkg::RST_WORD;
                cap_ctl[i]   <= mcct_pkg::RST_WORD;
            end else if (sel) begin
                if (wr_reg == mcct_pkg::OFS_PRE_VAL) begin
                    pre_val[i] <= merge_bytes(pre_val[i], wr_word, s_axi_wstrb) & MASK;
                end
                if (wr_reg == mcct_pkg::OFS_MATCH_CTL) begin
                    match_ctl[i] <= merge_bytes(match_ctl[i], wr_word, s_axi_wstrb) & mcct_pkg::MCTL_MASK;
                end
                if (wr_reg == mcct_pkg::OFS_CAP_CTL) begin
                    cap_ctl[i] <= merge_bytes(cap_ctl[i], wr_word, s_axi_wstrb) & mcct_pkg::CCTL_MASK;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            for (int j = 0; j < mcct_pkg::NUM_CH; j++) begin
                if (!rst_n) begin
                    match_val[i][j] <= mcct_pkg::RST_WORD;
                    cap_val[i][j]   <= mcct_pkg::RST_WORD;
                end else begin
                    if (sel && wr_reg == mcct_pkg::OFS_MATCH0 + 6'(j) * mcct_pkg::OFS_STEP) begin
                        match_val[i][j] <= merge_bytes(match_val[i][j], wr_word, s_axi_wstrb) & MASK;
                    end
                    if (c_hit[j]) begin
                        cap_val[i][j] <= count[i];
                    end
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                flags[i] <= 8'h00;
            end else if (sel && wr_reg == mcct_pkg::OFS_FLAGS && s_axi_wstrb[0]) begin
                flags[i] <= (flags[i] & ~wr_word[7:0]) | {c_hit, m_hit};
            end else begin
                flags[i] <= flags[i] | {c_hit, m_hit};
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                ext_ctl[i] <= mcct_pkg::RST_WORD;
            end else begin
                if (sel && wr_reg == mcct_pkg::OFS_EXT_CTL) begin
                    ext_ctl[i] <= merge_bytes(ext_ctl[i], wr_word, s_axi_wstrb) & mcct_pkg::EXT_MASK;
                end
                for (int j = 0; j < mcct_pkg::NUM_CH; j++) begin
                    if (m_hit[j]) begin
                        case (mcct_pkg::mcct_ext_action_type'(ext_ctl[i][mcct_pkg::EXT_ACT_LO + 2*j +: 2]))
                            mcct_pkg::EXT_LOW: begin
                                ext_ctl[i][j] <= 1'b0;
                            end
                            mcct_pkg::EXT_HIGH: begin
                                ext_ctl[i][j] <= 1'b1;
                            end
                            mcct_pkg::EXT_TOGGLE: begin
                                ext_ctl[i][j] <= !ext_ctl[i][j];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end

        // Level interrupt follows flags one cycle later
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                irq_q[i] <= 1'b0;
                dma_q[i] <= 1'b0;
            end else begin
                irq_q[i] <= |(flags[i] & int_en);
                dma_q[i] <= |(m_hit & ctrl[i][mcct_pkg::CTRL_DMA_LO +: 4]);
            end
        end
    end

endmodule
`default_nettype wire

/* File: test/mcct_asserts.sv */
// Bus handshake checks for the four-timer block
`timescale 1ns/100ps
`default_nettype none
module mcct_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [3:0]  timer_dma_req,
    input wire logic [3:0]  long_timer_a_match_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ========================================================================
    // Write channel
    aw_w_pair_a: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready differ");
    wr_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        && !s_axi_awready |=> s_axi_awready) else $error("write not taken");
    b_answer_a: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    no_wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    // ========================================================================
    // Read channel
    rd_take_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready) else $error("read not taken");
    r_answer_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (timer_dma_req[0]);
    cover property ($changed(long_timer_a_match_out[0]));
endmodule
bind mcct_top mcct_asserts u_mcct_asserts (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .timer_dma_req, .long_timer_a_match_out);
`default_nettype wire

/* File: test/mcct_pins_model.sv */
// Board model: match outputs wired back to capture pins
`timescale 1ns/100ps
`default_nettype none
module mcct_pins_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] match_out,
    output logic      [15:0] capture_in = 16'h0000
);
    // One flop of board delay, so pins follow the match outputs one rising edge later
    always @(posedge clk_sys) capture_in <= match_out;
endmodule
`default_nettype wire

/* File: test/tb_mcct_top.sv */
// Self-checking bench for the four-timer block
`timescale 1ns/100ps
`default_nettype none
module tb_mcct_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_wstrb = 4'hF, timer_irq, timer_dma_req;
    logic [1:0]  comparator_out = 2'h0, s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, d, v, mk;
    logic [15:0] cap, mo;
    int          n_mismatch = 0, samples_checked = 0, p, m, t, k;
    always #2 clk_sys = ~clk_sys;
    mcct_top u_mcct_top (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_out,
        .long_timer_a_capture_in(cap[3:0]), .long_timer_b_capture_in(cap[7:4]),
        .short_timer_a_capture_in(cap[11:8]), .short_timer_b_capture_in(cap[15:12]),
        .long_timer_a_match_out(mo[3:0]), .long_timer_b_match_out(mo[7:4]),
        .short_timer_a_match_out(mo[11:8]), .short_timer_b_match_out(mo[15:12]),
        .timer_irq, .timer_dma_req);
    mcct_pins_model u_mcct_pins_model (.clk_sys, .match_out(mo), .capture_in(cap));
    // ========================================================================
    // Helpers
    task automatic summarize;
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic lim(input int c);
        if (c == 99) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic await(ref logic s);
        int j;
        for (j = 0; j < 99 && s !== 1'b1; j++) @(posedge clk_sys);
        lim(j);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] x);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        await(s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        await(s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] x);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        await(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        await(s_axi_rvalid);
        x = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic logic [31:0] ad(input int n, input logic [5:0] o);
        return 32'(n * 64) + 32'(o);
    endfunction
    // ========================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hFCFA));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(32'h00000100, d);
        chk("bad_resp", 32'(mcct_pkg::RESP_SLVERR), {30'h0, resp});
        chk("bad_data", 32'h00000000, d);
        for (t = 0; t < 4; t++) begin
            mk = (t < 2) ? 32'hFFFFFFFF : 32'h0000FFFF;
            rd(ad(t, mcct_pkg::OFS_CTRL), d);
            chk("ctrl_reset", mcct_pkg::RST_WORD, d);
            v = $urandom();
            wr(ad(t, mcct_pkg::OFS_PRE_VAL), v);
            rd(ad(t, mcct_pkg::OFS_PRE_VAL), d);
            chk("prescale", v & mk, d);
            v = $urandom();
            wr(ad(t, mcct_pkg::OFS_MATCH0 + 6'h04), v);
            rd(ad(t, mcct_pkg::OFS_MATCH0 + 6'h04), d);
            chk("match1", v & mk, d);
        end
        p = $urandom_range(3);
        m = $urandom_range(5, 2);
        wr(ad(0, mcct_pkg::OFS_PRE_VAL), 32'(p));
        wr(ad(0, mcct_pkg::OFS_MATCH0), 32'(m));
        wr(ad(0, mcct_pkg::OFS_MATCH_CTL), 32'h00000003);
        wr(ad(0, mcct_pkg::OFS_EXT_CTL), 32'h00000030);
        wr(ad(0, mcct_pkg::OFS_CTRL), 32'h00000101);
        for (k = 0; k < 99 && timer_dma_req[0] !== 1'b1; k++) @(posedge clk_sys);
        lim(k);
        v = {16'h0, mo};
        @(posedge clk_sys);
        for (k = 1; k < 99 && timer_dma_req[0] !== 1'b1; k++) @(posedge clk_sys);
        lim(k);
        chk("period", 32'((p + 1) * m), 32'(k));
        chk("toggle", {31'h0, ~v[0]}, {31'h0, mo[0]});
        chk("irq_match", 32'h1, {31'h0, timer_irq[0]});
        wr(ad(0, mcct_pkg::OFS_CTRL), 32'h00000000);
        wr(ad(0, mcct_pkg::OFS_FLAGS), 32'h000000FF);
        rd(ad(0, mcct_pkg::OFS_FLAGS), d);
        chk("flags_clear", 32'h0, d);
        chk("irq_clear", 32'h0, {31'h0, timer_irq[0]});
        wr(ad(1, mcct_pkg::OFS_PRE_VAL), 32'h00000000);
        wr(ad(1, mcct_pkg::OFS_MATCH0), 32'(m));
        wr(ad(1, mcct_pkg::OFS_MATCH_CTL), 32'h00000004);
        wr(ad(1, mcct_pkg::OFS_CAP_CTL), 32'h00000005);
        wr(ad(1, mcct_pkg::OFS_CTRL), 32'h00000001);
        for (k = 0; k < 99; k++) begin
            rd(ad(1, mcct_pkg::OFS_CTRL), d);
            if (d[0] === 1'b0) break;
        end
        lim(k);
        rd(ad(1, mcct_pkg::OFS_COUNT), d);
        chk("stop_count", 32'(m), d);
        wr(ad(1, mcct_pkg::OFS_EXT_CTL), 32'h00000001);
        for (k = 0; k < 99; k++) begin
            rd(ad(1, mcct_pkg::OFS_FLAGS), d);
            if (d[4] === 1'b1) break;
        end
        lim(k);
        rd(ad(1, mcct_pkg::OFS_CAP0), d);
        chk("capture", 32'(m), d);
        chk("irq_capture", 32'h1, {31'h0, timer_irq[1]});
        wr(ad(1, mcct_pkg::OFS_CTRL), 32'h00000075);
        comparator_out <= 2'h2;
        repeat (8) @(posedge clk_sys);
        rd(ad(1, mcct_pkg::OFS_COUNT), d);
        chk("edge_count", 32'(m + 1), d);
        summarize();
    end
endmodule
`default_nettype wire
